/* File: verilog/parallel_port_config.sv */
// parallel port configuration register bank with mode views and gating
// assumes index/data decode upstream: cfg_idx holds the index of this device
module parallel_port_config
    import pp_pkg::*;
(
    input logic clk,
    input logic rst_n,
    input logic [7:0] cfg_idx,
    input logic [7:0] cfg_wdata,
    input logic cfg_wr,
    input logic cfg_rd,
    output logic [7:0] cfg_rdata,
    input logic global_device_enable,
    input logic port_fast_disable,
    input logic [2:0] ecr_mode,
    input logic second_control_reg_epp19,
    input rt_off_t rt_offset,
    input logic rt_rd,
    input logic rt_wr,
    output logic rt_hit,
    output logic port_active,
    output logic port_clk_en,
    output logic ecp_enable,
    output logic epp_timeout_en,
    output logic epp_is_19,
    output logic pins_float,
    output logic [2:0] port_mode,
    output logic [15:0] base_addr,
    output logic [7:0] irq_number,
    output logic irq_level,
    output logic [7:0] dma_channel
);
    // ======================================================
    // stored configuration
    logic [7:0] activate_r;
    logic [7:0] base_hi_r;
    logic [7:0] base_lo_r;
    logic [7:0] irq_num_r;
    logic irq_type_rw_r;
    logic [7:0] dma_sel_r;
    logic [2:0] mode_r;
    logic ext_r;
    logic pwr_r;
    logic float_r;
    logic [7:0] rdata_r;
    logic active_r;
    logic clk_en_r;
    logic ecp_en_r;
    logic epp_to_r;
    logic epp19_r;
    logic float_out_r;
    logic irq_level_r;
    logic [7:0] rd_mux;
    logic active_now;
    logic is_ecp;
    logic is_epp;
    logic level_now;

    // reset images sliced per field, so no reset value is cut by a shift
    localparam logic [7:0] STD_RST = `RST_STD_CFG;
    localparam logic [7:0] IRQ_TYPE_RST = `RST_IRQ_TYPE;

    mode_if mi();

    assign mi.std_mode = mode_r;
    assign mi.alt_code = cfg_wdata[3:0];
    assign mi.ext_access = ext_r;
    assign mi.active = active_r;
    assign mi.ecr_mode = ecr_mode;

    mode_map u_map (
        .m(mi)
    );

    rt_gate u_gate (
        .clk(clk),
        .rst_n(rst_n),
        .g(mi),
        .rt_offset(rt_offset),
        .rt_rd(rt_rd),
        .rt_wr(rt_wr),
        .rt_hit_r(rt_hit)
    );

    // ======================================================
    // plain read/write registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            activate_r <= `RST_ACTIVATE;
            base_hi_r <= `RST_BASE_HI;
            base_lo_r <= `RST_BASE_LO;
            irq_num_r <= `RST_IRQ_NUM;
            irq_type_rw_r <= IRQ_TYPE_RST[1];
            dma_sel_r <= `RST_DMA_SEL;
        end else if (cfg_wr) begin
            case (cfg_idx)
                `IDX_ACTIVATE: activate_r <= cfg_wdata & `MASK_ACTIVATE;
                // read-only zero bits never store; bit 2 is left to software
                `IDX_BASE_HI: base_hi_r <= cfg_wdata & `MASK_BASE_HI;
                `IDX_BASE_LO: base_lo_r <= cfg_wdata & `MASK_BASE_LO;
                `IDX_IRQ_NUM: irq_num_r <= cfg_wdata;
                `IDX_IRQ_TYPE: irq_type_rw_r <= cfg_wdata[1];
                `IDX_DMA_SEL: dma_sel_r <= cfg_wdata;
                default: ;
            endcase
        end
    end

    // ======================================================
    // the one mode store behind both views
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= STD_RST[`STD_MODE_MSB:`STD_MODE_LSB];
        end else if (cfg_wr && cfg_idx == `IDX_STD_CFG) begin
            mode_r <= cfg_wdata[`STD_MODE_MSB:`STD_MODE_LSB];
        end else if (cfg_wr && cfg_idx == `IDX_ALT_CFG && mi.alt_legal) begin
            mode_r <= mi.alt_std;
        end
    end

    // ======================================================
    // standard register control bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_r <= STD_RST[`STD_EXT_BIT];
            pwr_r <= STD_RST[`STD_PWR_BIT];
            float_r <= STD_RST[`STD_FLOAT_BIT];
        end else if (cfg_wr && cfg_idx == `IDX_STD_CFG) begin
            ext_r <= cfg_wdata[`STD_EXT_BIT];
            pwr_r <= cfg_wdata[`STD_PWR_BIT];
            float_r <= cfg_wdata[`STD_FLOAT_BIT];
        end
    end

    // ======================================================
    // derived state
    assign active_now = activate_r[0] && global_device_enable && !port_fast_disable;
    assign is_ecp = (mode_r == `STD_ECP) || (mode_r == `STD_ECP_EPP);
    assign is_epp = (mode_r == `STD_EPP17) || (mode_r == `STD_EPP19) || (mode_r == `STD_ECP_EPP);
    assign level_now = (mode_r == `STD_ECP_EPP) && ext_r;

    // ======================================================
    // read mux; reserved bits read zero
    always_comb begin
        case (cfg_idx)
            `IDX_ACTIVATE: rd_mux = activate_r;
            `IDX_BASE_HI: rd_mux = base_hi_r;
            `IDX_BASE_LO: rd_mux = base_lo_r;
            `IDX_IRQ_NUM: rd_mux = irq_num_r;
            `IDX_IRQ_TYPE: rd_mux = {6'h00, irq_type_rw_r, level_now};
            `IDX_DMA_SEL: rd_mux = dma_sel_r;
            `IDX_DMA2: rd_mux = `VAL_DMA2;
            `IDX_STD_CFG: rd_mux = {mode_r, ext_r, 2'h0, pwr_r, float_r};
            `IDX_ALT_CFG: rd_mux = {4'h0, mi.alt_view};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else if (cfg_rd) begin
            rdata_r <= rd_mux;
        end
    end

    // ======================================================
    // registered status toward the port engines
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_r <= 1'b0;
            clk_en_r <= 1'b0;
            ecp_en_r <= 1'b0;
            epp_to_r <= 1'b0;
            epp19_r <= 1'b0;
            float_out_r <= 1'b0;
            irq_level_r <= 1'b0;
        end else begin
            active_r <= active_now;
            // the clock stops but the registers above keep their contents
            clk_en_r <= active_now && pwr_r;
            ecp_en_r <= active_now && pwr_r && is_ecp;
            epp_to_r <= active_now && pwr_r && is_epp;
            epp19_r <= (mode_r == `STD_EPP19) ||
                ((mode_r == `STD_ECP_EPP) && second_control_reg_epp19);
            float_out_r <= float_r && !active_now;
            irq_level_r <= level_now;
        end
    end

    assign cfg_rdata = rdata_r;
    assign port_active = active_r;
    assign port_clk_en = clk_en_r;
    assign ecp_enable = ecp_en_r;
    assign epp_timeout_en = epp_to_r;
    assign epp_is_19 = epp19_r;
    assign pins_float = float_out_r;
    assign port_mode = mode_r;
    assign base_addr = {base_hi_r, base_lo_r};
    assign irq_number = irq_num_r;
    assign irq_level = irq_level_r;
    assign dma_channel = dma_sel_r;

    // ======================================================
    // checks
    a_std_mode_write: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg_wr && cfg_idx == `IDX_STD_CFG) |=> port_mode == $past(cfg_wdata[7:5]))
        else $error("standard mode write not stored");

    a_alt_view_follows: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg_rd && cfg_idx == `IDX_ALT_CFG && port_mode == `STD_SPP)
        |=> cfg_rdata == {4'h0, `ALT_SPP})
        else $error("modified view does not show compatible mode");

    a_alt_write_std: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg_wr && cfg_idx == `IDX_ALT_CFG && cfg_wdata[3:0] == `ALT_EPP17)
        |=> port_mode == `STD_EPP17)
        else $error("modified write did not update standard mode");

    a_clk_stopped: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg_wr && cfg_idx == `IDX_STD_CFG && !cfg_wdata[1]) |=> ##1 !port_clk_en && !ecp_enable)
        else $error("port clock runs with power bit clear");

    a_float_inactive: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg_wr && cfg_idx == `IDX_STD_CFG && cfg_wdata[0] && !activate_r[0])
        |=> !activate_r[0] |-> ##1 pins_float)
        else $error("outputs not floated while inactive");

    a_irq_type_read: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg_rd && cfg_idx == `IDX_IRQ_TYPE)
        |=> cfg_rdata[7:2] == 6'h00 && cfg_rdata[0] == $past(level_now))
        else $error("interrupt type read wrong");

    a_base_hi_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg_rd && cfg_idx == `IDX_BASE_HI) |=> cfg_rdata[7:3] == 5'h00)
        else $error("base high read-only bits not zero");

    a_dma2_const: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg_rd && cfg_idx == `IDX_DMA2) |=> cfg_rdata == `VAL_DMA2)
        else $error("second DMA report not 04h");

    a_fast_off: assert property (@(posedge clk) disable iff (!rst_n)
        port_fast_disable |=> !port_active && !port_clk_en)
        else $error("fast disable did not force port off");

    a_global_off: assert property (@(posedge clk) disable iff (!rst_n)
        !global_device_enable |=> !port_active)
        else $error("global enable low did not force port off");

    a_pwr_gates_modes: assert property (@(posedge clk) disable iff (!rst_n)
        !pwr_r |=> !port_clk_en && !ecp_enable && !epp_timeout_en)
        else $error("port engines enabled with power bit clear");

    a_drive_when_clear: assert property (@(posedge clk) disable iff (!rst_n)
        !float_r |=> !pins_float)
        else $error("outputs floated with float bit clear");

    a_drive_when_active: assert property (@(posedge clk) disable iff (!rst_n)
        active_now |=> !pins_float)
        else $error("outputs floated while device active");

    a_epp19_select: assert property (@(posedge clk) disable iff (!rst_n)
        mode_r == `STD_ECP_EPP |=> epp_is_19 == $past(second_control_reg_epp19))
        else $error("EPP version select not followed in mode 111");

    a_base_lo_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg_rd && cfg_idx == `IDX_BASE_LO) |=> cfg_rdata[1:0] == 2'h0)
        else $error("base low read-only bits not zero");

    a_mode_kept: assert property (@(posedge clk) disable iff (!rst_n)
        !(cfg_wr && (cfg_idx == `IDX_STD_CFG || cfg_idx == `IDX_ALT_CFG))
        |=> $stable(port_mode))
        else $error("stored mode changed without a mode write");

    a_std_read_view: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg_rd && cfg_idx == `IDX_STD_CFG) |=> cfg_rdata[7:5] == $past(port_mode) &&
        cfg_rdata[3:2] == 2'h0)
        else $error("standard view read wrong");

    a_irq_edge_type: assert property (@(posedge clk) disable iff (!rst_n)
        mode_r != `STD_ECP_EPP |=> !irq_level)
        else $error("level interrupt outside extended mode");

    a_active_causes: assert property (@(posedge clk) disable iff (!rst_n)
        port_active |-> $past(active_now))
        else $error("port active without activation and enables");

    a_ext_bit_stored: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg_wr && cfg_idx == `IDX_STD_CFG) |=> ext_r == $past(cfg_wdata[`STD_EXT_BIT]))
        else $error("extended access bit not stored");

    a_dma_sel_write: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg_wr && cfg_idx == `IDX_DMA_SEL) |=> dma_channel == $past(cfg_wdata))
        else $error("DMA select write not stored");

    a_irq_num_write: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg_wr && cfg_idx == `IDX_IRQ_NUM) |=> irq_number == $past(cfg_wdata))
        else $error("interrupt number write not stored");

    a_base_hi_write: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg_wr && cfg_idx == `IDX_BASE_HI) |=> base_addr[15:11] == 5'h00)
        else $error("base high read-only bits stored");

    c_alt_write: cover property (@(posedge clk) disable iff (!rst_n)
        cfg_wr && cfg_idx == `IDX_ALT_CFG && mi.alt_legal);
    c_port_on: cover property (@(posedge clk) disable iff (!rst_n) $rose(port_active));
    c_float: cover property (@(posedge clk) disable iff (!rst_n) pins_float);
endmodule // parallel_port_config

/* File: verilog/pp_consts.svh */
// constants of the parallel port configuration register bank
// assumes inclusion by the package and by the testbench only
`ifndef PP_CONSTS_SVH
`define PP_CONSTS_SVH

// ======================================================
// configuration indexes
`define IDX_ACTIVATE 8'h30
`define IDX_BASE_HI 8'h60
`define IDX_BASE_LO 8'h61
`define IDX_IRQ_NUM 8'h70
`define IDX_IRQ_TYPE 8'h71
`define IDX_DMA_SEL 8'h74
`define IDX_DMA2 8'h75
`define IDX_STD_CFG 8'hF0
`define IDX_ALT_CFG 8'hF8

// ======================================================
// reset values and writable masks
`define RST_ACTIVATE 8'h00
`define RST_BASE_HI 8'h02
`define RST_BASE_LO 8'h78
`define RST_IRQ_NUM 8'h07
`define RST_IRQ_TYPE 8'h02
`define RST_DMA_SEL 8'h04
`define VAL_DMA2 8'h04
`define RST_STD_CFG 8'hF2
`define RST_ALT_CFG 8'h07
`define MASK_BASE_HI 8'h07
`define MASK_BASE_LO 8'hFC
`define MASK_IRQ_TYPE 8'h02
`define MASK_ACTIVATE 8'h01

// ======================================================
// field positions
`define STD_MODE_MSB 7
`define STD_MODE_LSB 5
`define STD_EXT_BIT 4
`define STD_PWR_BIT 1
`define STD_FLOAT_BIT 0
`define IRQ_LEVEL_BIT 0

// ======================================================
// mode codes, standard and modified views
`define STD_SPP 3'h0
`define STD_BIDIR 3'h1
`define STD_EPP17 3'h2
`define STD_EPP19 3'h3
`define STD_ECP 3'h4
`define STD_ECP_EPP 3'h7
`define ALT_SPP 4'h8
`define ALT_BIDIR 4'h1
`define ALT_EPP17 4'hA
`define ALT_EPP19 4'h2
`define ALT_ECP 4'h4
`define ALT_ECP_EPP 4'h7
`define MODE_COUNT 6

// ======================================================
// runtime space
`define RT_EPP_LO 11'h003
`define RT_EPP_HI 11'h007
`define RT_ECP_LO 11'h400
`define RT_ECP_HI 11'h402
`define RT_EXT_LO 11'h403
`define RT_EXT_HI 11'h405
`define RT_SLOTS 14
`define RT_REGS 21
`define ECR_EPP_SUB 3'h4
`define DCR_MODE_CHANGE 8'hC4

`endif

/* File: verilog/pp_pkg.sv */
// types shared by the parallel port configuration modules
// assumes the constants header sits beside it
package pp_pkg;
`include "pp_consts.svh"

    typedef enum logic [2:0] {
        MODE_SPP = `STD_SPP,
        MODE_BIDIR = `STD_BIDIR,
        MODE_EPP17 = `STD_EPP17,
        MODE_EPP19 = `STD_EPP19,
        MODE_ECP = `STD_ECP,
        MODE_ECP_EPP = `STD_ECP_EPP
    } pp_mode_e;

    typedef logic [3:0] alt_code_t;
    typedef logic [10:0] rt_off_t;
endpackage

/* File: verilog/mode_if.sv */
// carrier between the configuration core and its helpers
// assumes one instance inside the top module
interface mode_if;
    logic [2:0] std_mode;
    logic [3:0] alt_view;
    logic [3:0] alt_code;
    logic [2:0] alt_std;
    logic alt_legal;
    logic ext_access;
    logic active;
    logic [2:0] ecr_mode;

    modport map (input std_mode, input alt_code, output alt_view, output alt_std,
                 output alt_legal);
    modport gate (input std_mode, input ext_access, input active, input ecr_mode);
    modport ctl (output std_mode, output alt_code, output ext_access, output active,
                 output ecr_mode, input alt_view, input alt_std, input alt_legal);
endinterface

/* File: verilog/mode_map.sv */
// translation between the 3-bit and 4-bit views of the port mode
// assumes the stored mode lives in the core; this module is pure logic
module mode_map
    import pp_pkg::*;
(
    mode_if.map m
);
    localparam logic [2:0] STD_TAB [`MODE_COUNT] = '{`STD_SPP, `STD_BIDIR, `STD_EPP17,
        `STD_EPP19, `STD_ECP, `STD_ECP_EPP};
    localparam logic [3:0] ALT_TAB [`MODE_COUNT] = '{`ALT_SPP, `ALT_BIDIR, `ALT_EPP17,
        `ALT_EPP19, `ALT_ECP, `ALT_ECP_EPP};

    logic [`MODE_COUNT-1:0] std_hit;
    logic [`MODE_COUNT-1:0] alt_hit;
    logic [3:0] view_part [`MODE_COUNT];
    logic [2:0] std_part [`MODE_COUNT];

    // one table entry per defined mode
    genvar i;
    for (i = 0; i < `MODE_COUNT; i++) begin : g_tab
        assign std_hit[i] = (m.std_mode == STD_TAB[i]);
        assign alt_hit[i] = (m.alt_code == ALT_TAB[i]);
        assign view_part[i] = std_hit[i] ? ALT_TAB[i] : 4'h0;
        assign std_part[i] = alt_hit[i] ? STD_TAB[i] : 3'h0;
    end

    always_comb begin
        m.alt_view = 4'h0;
        m.alt_std = 3'h0;
        for (int k = 0; k < `MODE_COUNT; k++) begin
            m.alt_view = m.alt_view | view_part[k];
            m.alt_std = m.alt_std | std_part[k];
        end
    end

    // reserved codes leave the stored mode alone
    assign m.alt_legal = |alt_hit;
endmodule // mode_map

/* File: verilog/rt_gate.sv */
// decides whether a runtime offset answers in the current mode
// assumes offsets arrive already relative to the port base address
module rt_gate
    import pp_pkg::*;
(
    input logic clk,
    input logic rst_n,
    mode_if.gate g,
    input rt_off_t rt_offset,
    input logic rt_rd,
    input logic rt_wr,
    output logic rt_hit_r
);
    logic is_ecp;
    logic is_epp;
    logic hit_nxt;

    assign is_ecp = (g.std_mode == `STD_ECP) || (g.std_mode == `STD_ECP_EPP);
    assign is_epp = (g.std_mode == `STD_EPP17) || (g.std_mode == `STD_EPP19) ||
        ((g.std_mode == `STD_ECP_EPP) && (g.ecr_mode == `ECR_EPP_SUB));

    always_comb begin
        hit_nxt = 1'b0;
        if (g.active && (rt_rd || rt_wr)) begin
            if (rt_offset < `RT_EPP_LO) begin
                hit_nxt = 1'b1;
            end else if (rt_offset <= `RT_EPP_HI) begin
                hit_nxt = is_epp;
            end else if (rt_offset >= `RT_ECP_LO && rt_offset <= `RT_ECP_HI) begin
                hit_nxt = is_ecp;
            end else if (rt_offset >= `RT_EXT_LO && rt_offset <= `RT_EXT_HI) begin
                // extended slots need ECP with EPP and software consent
                hit_nxt = (g.std_mode == `STD_ECP_EPP) && g.ext_access;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rt_hit_r <= 1'b0;
        end else begin
            rt_hit_r <= hit_nxt;
        end
    end

    a_ext_gated: assert property (@(posedge clk) disable iff (!rst_n)
        ((rt_rd || rt_wr) && rt_offset >= `RT_EXT_LO && rt_offset <= `RT_EXT_HI &&
         !g.ext_access) |=> !rt_hit_r)
        else $error("extended runtime slot answered with access disabled");

    c_ext_hit: cover property (@(posedge clk) disable iff (!rst_n) rt_hit_r &&
        $past(rt_offset) == `RT_EXT_LO);
endmodule // rt_gate

/* File: test/parallel_port_config_tb.sv */
// self-checking bench for the parallel port configuration register bank
// assumes the design sources and pp_consts.svh are reachable on the include path
`include "pp_consts.svh"

// ======================================================
// compare macro
`define CHK_EQ(got, exp) \
    begin \
        checks++; \
        if ((got) !== (exp)) begin \
            err_total++; \
            $display("[ERR] %0t ns: value %0h, expected %0h", $time, (got), (exp)); \
        end \
    end

module parallel_port_config_tb
    import pp_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [7:0] std;
        logic [2:0] extended_control_reg;
        rt_off_t off;
        logic hit;
    } rt_case_s;

    localparam logic [7:0] IDX_T [9] = '{`IDX_ACTIVATE, `IDX_BASE_HI, `IDX_BASE_LO,
        `IDX_IRQ_NUM, `IDX_IRQ_TYPE, `IDX_DMA_SEL, `IDX_DMA2, `IDX_STD_CFG, `IDX_ALT_CFG};
    // irq type bit 0 already reads 1: the reset mode is 111 with extended access on
    localparam logic [7:0] RST_T [9] = '{`RST_ACTIVATE, `RST_BASE_HI, `RST_BASE_LO,
        `RST_IRQ_NUM, `RST_IRQ_TYPE | 8'h01, `RST_DMA_SEL, `VAL_DMA2, `RST_STD_CFG,
        `RST_ALT_CFG};
    // value read back after writing FF; the modified view gets a defined code instead
    localparam logic [7:0] WFF_T [9] = '{`MASK_ACTIVATE, `MASK_BASE_HI, `MASK_BASE_LO,
        8'hFF, `MASK_IRQ_TYPE | 8'h01, 8'hFF, `VAL_DMA2, 8'hF3, `RST_ALT_CFG};
    localparam logic [2:0] STD_T [6] = '{`STD_SPP, `STD_BIDIR, `STD_EPP17, `STD_EPP19,
        `STD_ECP, `STD_ECP_EPP};
    localparam logic [3:0] ALT_T [6] = '{`ALT_SPP, `ALT_BIDIR, `ALT_EPP17, `ALT_EPP19,
        `ALT_ECP, `ALT_ECP_EPP};
    localparam rt_case_s RT_T [11] = '{
        '{8'hF2, 3'h0, 11'h403, 1'b1}, '{8'hE2, 3'h0, 11'h403, 1'b0},
        '{8'hF2, 3'h0, 11'h405, 1'b1}, '{8'hF2, 3'h0, 11'h406, 1'b0},
        '{8'h82, 3'h0, 11'h402, 1'b1}, '{8'h02, 3'h0, 11'h400, 1'b0},
        '{8'h02, 3'h0, 11'h000, 1'b1}, '{8'h62, 3'h0, 11'h003, 1'b1},
        '{8'hF2, 3'h4, 11'h007, 1'b1}, '{8'hF2, 3'h0, 11'h003, 1'b0},
        '{8'h92, 3'h0, 11'h403, 1'b0}};

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] cfg_idx = 8'h00;
    logic [7:0] cfg_wdata = 8'h00;
    logic cfg_wr = 1'b0;
    logic cfg_rd = 1'b0;
    logic [7:0] cfg_rdata;
    logic global_device_enable = 1'b1;
    logic port_fast_disable = 1'b0;
    logic [2:0] ecr_mode = 3'h0;
    logic second_control_reg_epp19 = 1'b0;
    rt_off_t rt_offset = 11'h000;
    logic rt_rd = 1'b0;
    logic rt_wr = 1'b0;
    logic rt_hit, port_active, port_clk_en, ecp_enable, epp_timeout_en, epp_is_19;
    logic pins_float, irq_level;
    logic [2:0] port_mode;
    logic [15:0] base_addr;
    logic [7:0] irq_number, dma_channel;
    int err_total = 0;
    int checks = 0;

    always #10 clk = ~clk;

    parallel_port_config u_parallel_port_config (
        .clk(clk), .rst_n(rst_n), .cfg_idx(cfg_idx), .cfg_wdata(cfg_wdata),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
        .global_device_enable(global_device_enable), .port_fast_disable(port_fast_disable),
        .ecr_mode(ecr_mode), .second_control_reg_epp19(second_control_reg_epp19),
        .rt_offset(rt_offset), .rt_rd(rt_rd), .rt_wr(rt_wr), .rt_hit(rt_hit),
        .port_active(port_active), .port_clk_en(port_clk_en), .ecp_enable(ecp_enable),
        .epp_timeout_en(epp_timeout_en), .epp_is_19(epp_is_19), .pins_float(pins_float),
        .port_mode(port_mode), .base_addr(base_addr), .irq_number(irq_number),
        .irq_level(irq_level), .dma_channel(dma_channel)
    );

    // ======================================================
    // access tasks: strobes rise and fall on falling edges, one idle cycle between
    task automatic wr(input logic [7:0] idx, input logic [7:0] data);
        @(negedge clk);
        cfg_idx = idx;
        cfg_wdata = data;
        cfg_wr = 1'b1;
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        @(negedge clk);
        cfg_idx = idx;
        cfg_rd = 1'b1;
        @(negedge clk);
        cfg_rd = 1'b0;
        `CHK_EQ(cfg_rdata, exp)
    endtask

    task automatic rt_chk(input rt_off_t off, input logic use_wr, input logic exp);
        @(negedge clk);
        rt_offset = off;
        rt_wr = use_wr;
        rt_rd = !use_wr;
        @(negedge clk);
        rt_wr = 1'b0;
        rt_rd = 1'b0;
        `CHK_EQ(rt_hit, exp)
    endtask

    // derived outputs lag a write by two edges
    task automatic settle;
        repeat (2) @(negedge clk);
    endtask

    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ======================================================
    // main sequence
    initial begin
        int j;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 9; i++) begin
            rd_chk(IDX_T[i], RST_T[i]);
        end
        rd_chk(8'hF1, 8'h00);
        wr(8'hF1, 8'hFF);
        rd_chk(8'hF1, 8'h00);
        for (int i = 0; i < 9; i++) begin
            wr(IDX_T[i], (IDX_T[i] == `IDX_ALT_CFG) ? {4'h0, `ALT_ECP_EPP} : 8'hFF);
            rd_chk(IDX_T[i], WFF_T[i]);
        end
        `CHK_EQ(base_addr, 16'h07FC)
        `CHK_EQ(irq_number, 8'hFF)
        `CHK_EQ(dma_channel, 8'hFF)
        wr(`IDX_STD_CFG, `RST_STD_CFG);
        settle();
        for (int i = 0; i < `MODE_COUNT; i++) begin
            j = (i + 1) % `MODE_COUNT;
            rt_chk(11'h002, 1'b1, 1'b1);
            wr(`IDX_STD_CFG, {STD_T[i], 5'h12});
            rd_chk(`IDX_ALT_CFG, {4'h0, ALT_T[i]});
            `CHK_EQ(port_mode, STD_T[i])
            wr(`IDX_ALT_CFG, {4'h0, ALT_T[j]});
            rd_chk(`IDX_STD_CFG, {STD_T[j], 5'h12});
        end
        rt_chk(11'h002, 1'b1, 1'b1);
        wr(`IDX_ALT_CFG, {4'h0, `ALT_BIDIR});
        rd_chk(`IDX_ALT_CFG, {4'h0, `ALT_BIDIR});
        rd_chk(`IDX_STD_CFG, {`STD_BIDIR, 5'h12});
        // ======================================================
        // mode derived controls
        rt_chk(11'h002, 1'b1, 1'b1);
        wr(`IDX_STD_CFG, 8'hF2);
        second_control_reg_epp19 = 1'b1;
        settle();
        `CHK_EQ({port_clk_en, ecp_enable, epp_timeout_en, irq_level}, 4'hF)
        `CHK_EQ(epp_is_19, 1'b1)
        second_control_reg_epp19 = 1'b0;
        settle();
        `CHK_EQ(epp_is_19, 1'b0)
        wr(`IDX_STD_CFG, 8'hF0);
        settle();
        `CHK_EQ({port_clk_en, ecp_enable, epp_timeout_en}, 3'h0)
        rd_chk(`IDX_STD_CFG, 8'hF0);
        rt_chk(11'h002, 1'b1, 1'b1);
        wr(`IDX_STD_CFG, 8'h62);
        settle();
        `CHK_EQ({ecp_enable, epp_timeout_en, epp_is_19, irq_level}, 4'h6)
        rt_chk(11'h002, 1'b1, 1'b1);
        wr(`IDX_STD_CFG, 8'hF3);
        settle();
        `CHK_EQ({port_active, pins_float}, 2'b10)
        port_fast_disable = 1'b1;
        settle();
        `CHK_EQ({port_active, pins_float}, 2'b01)
        port_fast_disable = 1'b0;
        global_device_enable = 1'b0;
        settle();
        `CHK_EQ({port_active, port_clk_en}, 2'b00)
        global_device_enable = 1'b1;
        settle();
        `CHK_EQ({port_active, pins_float}, 2'b10)
        // ======================================================
        // runtime decode per mode
        for (int i = 0; i < 11; i++) begin
            rt_chk(11'h002, 1'b1, 1'b1);
            wr(`IDX_STD_CFG, RT_T[i].std);
            ecr_mode = RT_T[i].extended_control_reg;
            settle();
            rt_chk(RT_T[i].off, 1'b0, RT_T[i].hit);
        end
        @(negedge clk);
        `CHK_EQ(rt_hit, 1'b0)
        wr(`IDX_ACTIVATE, 8'h00);
        settle();
        rt_chk(11'h000, 1'b0, 1'b0);
        wr(`IDX_STD_CFG, 8'h93);
        settle();
        `CHK_EQ({port_active, pins_float}, 2'b01)
        // second reset in mid-run brings the defaults back
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        rd_chk(`IDX_STD_CFG, `RST_STD_CFG);
        rd_chk(`IDX_ALT_CFG, `RST_ALT_CFG);
        wrap_up();
    end

    // the whole sequence needs a few hundred cycles; a hang is cut short here
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        wrap_up();
    end
endmodule // parallel_port_config_tb
